// File: svs_pkg.sv
package svs_pkg;
	// Register byte offsets, one aligned word each
	localparam logic [3:0] ADDR_ENABLE = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h8;
	localparam logic [3:0] ADDR_FLAGS = 4'hc;
	// Field positions in the enable register
	localparam int SENSE_LEVEL_BIT = 0;
	localparam int SENSE_ADC_BIT = 1;
	localparam int SUPPLY_LEVEL_BIT = 2;
	localparam int SUPPLY_ADC_BIT = 3;
	localparam int LOW_SEL_LSB = 4;
	localparam int HIGH_SEL_BIT = 6;
	// Field positions in status, irq enable and flag registers
	localparam int LOW_BIT = 0;
	localparam int HIGH_BIT = 1;
	// Values after reset
	localparam logic [6:0] ENABLE_RESET = 7'h00;
	localparam logic [1:0] IRQ_ENABLE_RESET = 2'h0;
	localparam logic [1:0] FLAGS_RESET = 2'h0;
	// Cycles the conditions stay frozen after stop, path plus synchroniser
	localparam int STOP_SETTLE = 3;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: svs_sync.sv
module svs_sync #(
	parameter int WIDTH = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	// Two flip-flops per bit, first stage read only by the second
	always_ff @(posedge clk) begin
		if (rst) begin
			stage1 <= '0;
			sync_out <= '0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule // svs_sync

// File: svs_top.sv
// Behaviour
// - interrupt request not gated by level sensing enable
// - two-bit field picks one of four lows
// - one bit picks first or second high
// - low flag sets on any low change
// - low flag cleared only by write one
// - low enable and flag request interrupt
// - high flag sets on any high change
// - high flag cleared only by write one
// - high enable and flag request interrupt
// - both sources ORed into one request
// - sensing disabled forces conditions to zero
// - disabling during active condition sets flag
// - interrupt request only in run mode
// - stop mode leaves change flags untouched
// - level sense and adc on separate pins
// - sense-pin level enable clears supply-pin level
// - sense-pin adc enable clears supply-pin adc
// - stop opens paths, configuration kept
module svs_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic stop_mode,
	input wire logic [3:0] sense_low_cmp,
	input wire logic [1:0] sense_high_cmp,
	input wire logic [3:0] supply_low_cmp,
	input wire logic [1:0] supply_high_cmp,
	output logic battery_sense_pin_path,
	output logic chip_supply_pin_path,
	output logic sense_pin_adc_connect,
	output logic supply_pin_adc_connect,
	output logic module_irq_request
);
	////////////////////////////////////////////////////////////////////////
	// Configuration state
	logic sense_pin_level_enable;
	logic supply_pin_level_enable;
	logic sense_pin_adc_enable;
	logic supply_pin_adc_enable;
	logic [1:0] low_threshold_select;
	logic high_threshold_select;
	logic low_irq_enable;
	logic high_irq_enable;
	logic low_change_flag;
	logic high_change_flag;
	logic low_condition;
	logic high_condition;
	logic low_condition_prev;
	logic high_condition_prev;
	logic stop_meta;
	logic stop_sync;
	logic [svs_pkg::STOP_SETTLE-1:0] stop_hist;
	logic sense_hold;
	logic [11:0] cmp_sync;

	// AXI bookkeeping
	logic aw_held;
	logic w_held;
	logic [3:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic [31:0] read_word;
	logic read_hit;
	logic write_hit;
	logic flag_write;
	logic [1:0] clear_mask;
	logic level_active;
	logic next_low_condition;
	logic next_high_condition;
	logic low_change;
	logic high_change;
	logic low_condition_irq;
	logic high_condition_irq;

	// Word address of a byte address
	function automatic logic [3:0] word_addr(input logic [31:0] a);
		return {a[3:2], 2'b00};
	endfunction

	// Decode whether an address hits a register
	function automatic logic addr_hit(input logic [31:0] a);
		return (a[31:4] == 28'h000_0000);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Comparator and stop synchronisers
	svs_sync #(.WIDTH(12)) u_cmp_sync (
		.clk(clk),
		.rst(rst),
		.async_in({supply_high_cmp, supply_low_cmp, sense_high_cmp, sense_low_cmp}),
		.sync_out(cmp_sync)
	);

	// Stop mode request crosses in two flip-flops, then a settle history
	always_ff @(posedge clk) begin
		if (rst) begin
			stop_meta <= 1'b0;
			stop_sync <= 1'b0;
			stop_hist <= '0;
		end else begin
			stop_meta <= stop_mode;
			stop_sync <= stop_meta;
			stop_hist <= {stop_hist[svs_pkg::STOP_SETTLE-2:0], stop_sync};
		end
	end

	// Freeze conditions in stop and until reopened paths have settled
	assign sense_hold = stop_sync | (|stop_hist);

	////////////////////////////////////////////////////////////////////////
	// Condition logic
	assign level_active = (sense_pin_level_enable | supply_pin_level_enable) & ~stop_sync;

	// Threshold pick and source pick
	always_comb begin
		next_low_condition = 1'b0;
		next_high_condition = 1'b0;
		if (level_active) begin
			if (sense_pin_level_enable) begin
				next_low_condition = cmp_sync[low_threshold_select];
				next_high_condition = cmp_sync[4 + {31'd0, high_threshold_select}];
			end else begin
				next_low_condition = cmp_sync[6 + {30'd0, low_threshold_select}];
				next_high_condition = cmp_sync[10 + {31'd0, high_threshold_select}];
			end
		end
	end

	// Registered conditions, forced low when sensing is off, frozen in stop
	always_ff @(posedge clk) begin
		if (rst) begin
			low_condition <= 1'b0;
			high_condition <= 1'b0;
		end else if (!sense_hold) begin
			low_condition <= next_low_condition;
			high_condition <= next_high_condition;
		end
	end

	// One registered copy for edge detection
	always_ff @(posedge clk) begin
		if (rst) begin
			low_condition_prev <= 1'b0;
			high_condition_prev <= 1'b0;
		end else begin
			low_condition_prev <= low_condition;
			high_condition_prev <= high_condition;
		end
	end

	assign low_change = low_condition ^ low_condition_prev;
	assign high_change = high_condition ^ high_condition_prev;

	////////////////////////////////////////////////////////////////////////
	// AXI write channel
	assign do_write = aw_held & w_held & ~s_axi_bvalid;
	assign write_hit = addr_hit({28'd0, aw_addr});
	assign flag_write = do_write & (aw_addr == svs_pkg::ADDR_FLAGS) & w_strb[0];
	assign clear_mask = flag_write ? w_data[1:0] : 2'b00;

	// Address and data taken in either order
	always_ff @(posedge clk) begin
		if (rst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready <= ~w_held & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= addr_hit(s_axi_awaddr) ? word_addr(s_axi_awaddr) : 4'h3;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	// Write response
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= svs_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (write_hit && aw_addr[1:0] == 2'b00) ? svs_pkg::RESP_OKAY : svs_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration register, kept through stop mode
	always_ff @(posedge clk) begin
		if (rst) begin
			{high_threshold_select, low_threshold_select, supply_pin_adc_enable,
				supply_pin_level_enable, sense_pin_adc_enable, sense_pin_level_enable}
				<= svs_pkg::ENABLE_RESET;
		end else if (do_write && aw_addr == svs_pkg::ADDR_ENABLE && w_strb[0]) begin
			high_threshold_select <= w_data[svs_pkg::HIGH_SEL_BIT];
			low_threshold_select <= w_data[svs_pkg::LOW_SEL_LSB +: 2];
			sense_pin_level_enable <= w_data[svs_pkg::SENSE_LEVEL_BIT];
			sense_pin_adc_enable <= w_data[svs_pkg::SENSE_ADC_BIT];
			// Supply enables settable only when the same write leaves the sense enable clear
			supply_pin_level_enable <= w_data[svs_pkg::SUPPLY_LEVEL_BIT]
				& ~w_data[svs_pkg::SENSE_LEVEL_BIT];
			supply_pin_adc_enable <= w_data[svs_pkg::SUPPLY_ADC_BIT]
				& ~w_data[svs_pkg::SENSE_ADC_BIT];
		end
	end

	// Interrupt enable register
	always_ff @(posedge clk) begin
		if (rst) begin
			{high_irq_enable, low_irq_enable} <= svs_pkg::IRQ_ENABLE_RESET;
		end else if (do_write && aw_addr == svs_pkg::ADDR_IRQ_ENABLE && w_strb[0]) begin
			low_irq_enable <= w_data[svs_pkg::LOW_BIT];
			high_irq_enable <= w_data[svs_pkg::HIGH_BIT];
		end
	end

	// Sticky change flags, set wins over clear, stop has no effect
	always_ff @(posedge clk) begin
		if (rst) begin
			{high_change_flag, low_change_flag} <= svs_pkg::FLAGS_RESET;
		end else begin
			low_change_flag <= low_change | (low_change_flag & ~clear_mask[svs_pkg::LOW_BIT]);
			high_change_flag <= high_change | (high_change_flag & ~clear_mask[svs_pkg::HIGH_BIT]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt combine
	assign low_condition_irq = low_irq_enable & low_change_flag;
	assign high_condition_irq = high_irq_enable & high_change_flag;

	// Request only in run mode
	always_ff @(posedge clk) begin
		if (rst) begin
			module_irq_request <= 1'b0;
		end else begin
			module_irq_request <= (low_condition_irq | high_condition_irq) & ~stop_sync;
		end
	end

	// Analog path controls, opened in stop mode
	always_ff @(posedge clk) begin
		if (rst) begin
			battery_sense_pin_path <= 1'b0;
			chip_supply_pin_path <= 1'b0;
			sense_pin_adc_connect <= 1'b0;
			supply_pin_adc_connect <= 1'b0;
		end else begin
			battery_sense_pin_path <= (sense_pin_level_enable | sense_pin_adc_enable) & ~stop_sync;
			chip_supply_pin_path <= (supply_pin_level_enable | supply_pin_adc_enable) & ~stop_sync;
			sense_pin_adc_connect <= sense_pin_adc_enable & ~stop_sync;
			supply_pin_adc_connect <= supply_pin_adc_enable & ~stop_sync;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI read channel
	always_comb begin
		read_word = 32'h0000_0000;
		read_hit = addr_hit(s_axi_araddr);
		unique case (word_addr(s_axi_araddr))
			svs_pkg::ADDR_ENABLE: read_word[6:0] = {high_threshold_select, low_threshold_select,
				supply_pin_adc_enable, supply_pin_level_enable, sense_pin_adc_enable,
				sense_pin_level_enable};
			svs_pkg::ADDR_STATUS: read_word[1:0] = {high_condition, low_condition};
			svs_pkg::ADDR_IRQ_ENABLE: read_word[1:0] = {high_irq_enable, low_irq_enable};
			svs_pkg::ADDR_FLAGS: read_word[1:0] = {high_change_flag, low_change_flag};
			default: read_hit = 1'b0;
		endcase
	end

	// One read at a time, answer the cycle after acceptance
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= svs_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= read_hit ? read_word : 32'h0000_0000;
				s_axi_rresp <= read_hit ? svs_pkg::RESP_OKAY : svs_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // svs_top

// File: svs_chk.sv
module svs_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic stop_mode,
	input wire logic battery_sense_pin_path,
	input wire logic chip_supply_pin_path,
	input wire logic sense_pin_adc_connect,
	input wire logic supply_pin_adc_connect,
	input wire logic module_irq_request
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	logic [3:0] since_wr;
	//////////////////////////////////////////////////
	// Cycles since the last write answer or stop request
	always_ff @(posedge clk) begin
		if (rst || s_axi_bvalid || stop_mode)
			since_wr <= 4'h0;
		else if (since_wr != 4'hf)
			since_wr <= since_wr + 4'h1;
	end
	//////////////////////////////////////////////////
	// Request line and sensing paths
	a_irq_stop_mask: assert property (stop_mode [*5] |-> !module_irq_request)
		else $error("irq request while stopped");
	a_path_stop_open: assert property (stop_mode [*5] |-> !(battery_sense_pin_path || chip_supply_pin_path))
		else $error("divider path closed while stopped");
	a_adc_one_pin: assert property (!(sense_pin_adc_connect && supply_pin_adc_connect))
		else $error("both pins routed to adc");
	a_irq_fall_cause: assert property ($fell(module_irq_request) |-> since_wr < 4'h6)
		else $error("irq dropped without write or stop");
	// Bus handshakes
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer not held");
	a_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer not held");
	a_aw_one_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready longer than one cycle");
	c_irq_rise: cover property ($rose(module_irq_request));
	c_stop_exit: cover property (stop_mode [*5] ##1 !stop_mode);
	c_read: cover property (s_axi_arvalid && s_axi_arready);
endmodule // svs_chk

// File: svs_cmp_model.sv
module svs_cmp_model #(
	parameter int LOW_BASE = 5000,
	parameter int LOW_STEP = 500,
	parameter int HIGH_BASE = 16000,
	parameter int HIGH_STEP = 2000
) (
	input wire logic sense_path,
	input wire logic supply_path,
	input wire logic [15:0] sense_mv,
	input wire logic [15:0] supply_mv,
	output logic [3:0] sense_low_cmp,
	output logic [1:0] sense_high_cmp,
	output logic [3:0] supply_low_cmp,
	output logic [1:0] supply_high_cmp
);
	//////////////////////////////////////////////////
	// Open divider leaves comparator input at ground
	function automatic logic [5:0] compare(input logic on, input logic [15:0] mv);
		int v;
		v = on ? int'(mv) : 0;
		for (int n = 0; n < 4; n++)
			compare[n] = v < LOW_BASE + n * LOW_STEP;
		for (int n = 0; n < 2; n++)
			compare[4 + n] = v >= HIGH_BASE + n * HIGH_STEP;
	endfunction
	// One comparator bank per pin
	assign {sense_high_cmp, sense_low_cmp} = compare(sense_path, sense_mv);
	assign {supply_high_cmp, supply_low_cmp} = compare(supply_path, supply_mv);
endmodule // svs_cmp_model

// File: supply_voltage_sense_irq_test.sv
module supply_voltage_sense_irq_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int lb = 5000;
	localparam int ls = 500;
	localparam int hb = 16000;
	localparam int hs = 2000;
	localparam int mid = 10000;
	localparam logic [31:0] r_en = 32'(svs_pkg::ADDR_ENABLE);
	localparam logic [31:0] r_st = 32'(svs_pkg::ADDR_STATUS);
	localparam logic [31:0] r_ie = 32'(svs_pkg::ADDR_IRQ_ENABLE);
	localparam logic [31:0] r_fl = 32'(svs_pkg::ADDR_FLAGS);
	logic clk, rst, stop_mode, module_irq_request;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0] s_axi_wstrb, sense_low_cmp, supply_low_cmp;
	logic [1:0] s_axi_bresp, s_axi_rresp, sense_high_cmp, supply_high_cmp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic battery_sense_pin_path, chip_supply_pin_path, sense_pin_adc_connect, supply_pin_adc_connect;
	logic [15:0] sense_mv, supply_mv;
	int fails, n_checks;
	//////////////////////////////////////////////////
	// Block under test and comparators
	svs_top uut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .stop_mode, .sense_low_cmp, .sense_high_cmp, .supply_low_cmp,
		.supply_high_cmp, .battery_sense_pin_path, .chip_supply_pin_path, .sense_pin_adc_connect,
		.supply_pin_adc_connect, .module_irq_request);
	svs_cmp_model #(.LOW_BASE(lb), .LOW_STEP(ls), .HIGH_BASE(hb), .HIGH_STEP(hs)) cmp (
		.sense_path(battery_sense_pin_path), .supply_path(chip_supply_pin_path), .sense_mv,
		.supply_mv, .sense_low_cmp, .sense_high_cmp, .supply_low_cmp, .supply_high_cmp);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	//////////////////////////////////////////////////
	// Compare, bus cycles, voltage steps
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (n = 0; n < 60; n++) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) break;
			s_axi_bready <= s_axi_bvalid;
		end
		s_axi_bready <= 1'b0;
		chk(32'(n < 60), 32'h1);
		chk(32'(s_axi_bresp), 32'(a > 32'hf ? svs_pkg::RESP_SLVERR : svs_pkg::RESP_OKAY));
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		int n;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 60; n++) begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) break;
			s_axi_rready <= s_axi_rvalid;
		end
		s_axi_rready <= 1'b0;
		chk(32'(n < 60), 32'h1);
		chk(32'(s_axi_rresp), 32'(a > 32'hf ? svs_pkg::RESP_SLVERR : svs_pkg::RESP_OKAY));
		chk(s_axi_rdata, e);
	endtask
	task automatic vs(input int v);
		@(posedge clk);
		sense_mv <= 16'(v);
		repeat (10) @(posedge clk);
	endtask
	//////////////////////////////////////////////////
	// Scenarios
	task automatic t_map;
		for (int i = 0; i < 4; i++)
			rd(32'(4 * i), 32'h0);
		wr(32'h10, 32'h1);
		rd(32'h10, 32'h0);
		wr(r_st, 32'h3);
		rd(r_st, 32'h0);
	endtask
	task automatic t_prec;
		wr(r_en, 32'h6);
		repeat (8) @(posedge clk);
		rd(r_st, 32'h1);
		chk(32'({battery_sense_pin_path, chip_supply_pin_path}), 32'h3);
		wr(r_en, 32'h5);
		rd(r_en, 32'h1);
		wr(r_en, 32'ha);
		rd(r_en, 32'h2);
		chk(32'({sense_pin_adc_connect, supply_pin_adc_connect}), 32'h2);
	endtask
	task automatic t_low;
		for (int c = 0; c < 4; c++) begin
			wr(r_en, 32'(16 * c + 1));
			vs(lb + c * ls - 1);
			rd(r_st, 32'h1);
			vs(lb + c * ls);
			rd(r_st, 32'h0);
		end
	endtask
	task automatic t_high;
		for (int s = 0; s < 2; s++) begin
			wr(r_en, 32'(64 * s + 1));
			vs(hb + s * hs);
			rd(r_st, 32'h2);
			vs(hb + s * hs - 1);
			rd(r_st, 32'h0);
		end
	endtask
	task automatic t_flags;
		wr(r_en, 32'h1);
		vs(mid);
		wr(r_fl, 32'h3);
		rd(r_fl, 32'h0);
		wr(r_ie, 32'h1);
		vs(lb - 1);
		rd(r_fl, 32'h1);
		chk(32'(module_irq_request), 32'h1);
		wr(r_fl, 32'h0);
		vs(mid);
		rd(r_fl, 32'h1);
		wr(r_fl, 32'h1);
		rd(r_fl, 32'h0);
		chk(32'(module_irq_request), 32'h0);
		wr(r_ie, 32'h2);
		vs(hb);
		rd(r_fl, 32'h2);
		chk(32'(module_irq_request), 32'h1);
		wr(r_fl, 32'h1);
		rd(r_fl, 32'h2);
		wr(r_fl, 32'h2);
		vs(mid);
		rd(r_fl, 32'h2);
	endtask
	task automatic t_stop;
		vs(lb - 1);
		wr(r_fl, 32'h1);
		rd(r_fl, 32'h2);
		@(posedge clk);
		stop_mode <= 1'b1;
		repeat (8) @(posedge clk);
		chk(32'({module_irq_request, battery_sense_pin_path}), 32'h0);
		rd(r_en, 32'h1);
		rd(r_fl, 32'h2);
		stop_mode <= 1'b0;
		repeat (8) @(posedge clk);
		rd(r_fl, 32'h2);
		rd(r_st, 32'h1);
		chk(32'(module_irq_request), 32'h1);
	endtask
	task automatic t_off;
		wr(r_ie, 32'h1);
		vs(lb - 1);
		wr(r_fl, 32'h3);
		wr(r_en, 32'h0);
		repeat (8) @(posedge clk);
		rd(r_st, 32'h0);
		rd(r_fl, 32'h1);
		chk(32'(module_irq_request), 32'h1);
		wr(r_ie, 32'h0);
		wr(r_fl, 32'h3);
		vs(hb);
		rd(r_fl, 32'h0);
		chk(32'(module_irq_request), 32'h0);
	endtask
	task automatic end_sim;
		if (fails == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	//////////////////////////////////////////////////
	// Main sequence
	initial begin
		rst = 1'b1;
		stop_mode = 1'b0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		sense_mv = 16'(mid);
		supply_mv = 16'(lb - 1);
		fails = 0;
		n_checks = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_map;
		t_prec;
		t_low;
		t_high;
		t_flags;
		t_stop;
		t_off;
		end_sim;
	end
	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		end_sim;
	end
endmodule // supply_voltage_sense_irq_test

bind svs_top svs_chk chk (.clk, .rst, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .stop_mode,
	.battery_sense_pin_path, .chip_supply_pin_path, .sense_pin_adc_connect,
	.supply_pin_adc_connect, .module_irq_request);
